/* File: rtl/hlc_regs.sv */
// Host and bus side control registers with cycle timer and byte lane steering
`timescale 1ns/1ps
module hlc_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        tick_24m,
  input  wire logic        ext_tick,
  input  wire logic        bus_reset_active,
  input  wire logic        phy_is_root,
  input  wire logic        overlong_cycle_event,
  input  wire logic        async_receive_enabled,
  input  wire logic        rx_cycle_start_valid,
  input  wire logic [31:0] rx_cycle_start_time,
  input  wire logic [3:0]  pkt_tcode,
  input  wire logic        pkt_is_header,
  input  wire logic [31:0] quadlet_in,
  output logic      [31:0] quadlet_out,
  output logic             link_active,
  output logic             early_ack_writes_on,
  output logic             accept_phy_packets,
  output logic             accept_identity_packets,
  output logic             cycle_start_send,
  output logic      [31:0] cycle_time_out,
  output logic             controller_reset
);
  logic [31:0] host_ctl_flags_reg;
  logic [31:0] bus_side_ctl_flags_reg;
  logic [2:0]  ext_sync_reg;
  logic        ext_seen_reg;
  logic        overlong_flag_reg;
  logic        root_reg;
  logic [2:0]  reset_cnt_reg;
  logic [11:0] offset_reg;
  logic [12:0] count_reg;
  logic [6:0]  seconds_reg;
  logic        soft_busy;
  logic        host_set_wr;
  logic        host_clr_wr;
  logic        bus_set_wr;
  logic        bus_clr_wr;
  logic        ext_rise;
  logic        rollover;
  logic        swap_code;
  logic        do_swap;

  // Decoded writes land at the strobe edge, so a read right after sees them
  assign host_set_wr = reg_write && reg_addr == hlc_pkg::HOST_SET_ADDR;
  assign host_clr_wr = reg_write && reg_addr == hlc_pkg::HOST_CLEAR_ADDR;
  assign bus_set_wr  = reg_write && reg_addr == hlc_pkg::BUS_SET_ADDR;
  assign bus_clr_wr  = reg_write && reg_addr == hlc_pkg::BUS_CLEAR_ADDR;
  assign soft_busy   = host_ctl_flags_reg[hlc_pkg::HC_SELF_RESET_BIT];

  // Host control flags; self reset wipes all but the busy bit itself
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_ctl_flags_reg <= hlc_pkg::HOST_RESET_VALUE;
    end else if (soft_busy) begin
      if (reset_cnt_reg == 3'(hlc_pkg::SELF_RESET_CYCLES - 1)) begin
        host_ctl_flags_reg <= hlc_pkg::HOST_RESET_VALUE;
      end else begin
        host_ctl_flags_reg <= hlc_pkg::HOST_RESET_VALUE;
        host_ctl_flags_reg[hlc_pkg::HC_SELF_RESET_BIT] <= 1'b1;
      end
    end else if (host_set_wr) begin
      host_ctl_flags_reg <= host_ctl_flags_reg | (reg_wdata & hlc_pkg::HOST_WRITABLE);
    end else if (host_clr_wr) begin
      host_ctl_flags_reg <= host_ctl_flags_reg & ~(reg_wdata & hlc_pkg::HOST_WRITABLE);
    end
  end

  // Self reset length counter
  always_ff @(posedge clk) begin
    if (!reset_n || !soft_busy) begin
      reset_cnt_reg <= 3'h0;
    end else begin
      reset_cnt_reg <= reset_cnt_reg + 3'h1;
    end
  end

  // Bus side flags; overlong event beats an originator set in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n || soft_busy) begin
      bus_side_ctl_flags_reg <= hlc_pkg::BUS_RESET_VALUE;
    end else begin
      if (bus_set_wr) begin
        bus_side_ctl_flags_reg <= bus_side_ctl_flags_reg
          | (reg_wdata & hlc_pkg::BUS_WRITABLE);
        if (overlong_flag_reg || overlong_cycle_event) begin
          bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT] <= 1'b0;
        end
      end else if (bus_clr_wr) begin
        bus_side_ctl_flags_reg <= bus_side_ctl_flags_reg
          & ~(reg_wdata & hlc_pkg::BUS_WRITABLE);
      end else if (overlong_cycle_event) begin
        bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT] <= 1'b0;
      end
      if (bus_clr_wr && overlong_cycle_event) begin
        bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT] <= 1'b0;
      end
    end
  end

  // Overlong event flag, write one to event address clears; set wins
  always_ff @(posedge clk) begin
    if (!reset_n || soft_busy) begin
      overlong_flag_reg <= 1'b0;
    end else if (overlong_cycle_event) begin
      overlong_flag_reg <= 1'b1;
    end else if (reg_write && reg_addr == hlc_pkg::EVENT_ADDR
                 && reg_wdata[hlc_pkg::EV_OVERLONG_BIT]) begin
      overlong_flag_reg <= 1'b0;
    end
  end

  // Root status caught only while bus reset runs
  always_ff @(posedge clk) begin
    if (!reset_n || soft_busy) begin
      root_reg <= 1'b0;
    end else if (bus_reset_active) begin
      root_reg <= phy_is_root;
    end
  end

  // External tick is a pin: three stages, edge once stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_sync_reg <= 3'h0;
      ext_seen_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_tick};
      if (ext_sync_reg[2] == ext_sync_reg[1]) begin
        ext_seen_reg <= ext_sync_reg[2];
      end
    end
  end
  assign ext_rise = ext_sync_reg[2] && ext_sync_reg[1] && !ext_seen_reg;

  // Rollover source choice
  always_comb begin
    if (bus_side_ctl_flags_reg[hlc_pkg::BS_EXT_TICK_BIT]) begin
      rollover = ext_rise;
    end else begin
      rollover = tick_24m && offset_reg == 12'(hlc_pkg::CYCLE_TICKS - 1);
    end
  end

  // Cycle timer; received cycle start reloads when link active and not originating
  always_ff @(posedge clk) begin
    if (!reset_n || soft_busy) begin
      offset_reg  <= 12'h000;
      count_reg   <= 13'h0000;
      seconds_reg <= 7'h00;
    end else if (rx_cycle_start_valid && link_active
                 && !bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT]) begin
      offset_reg  <= rx_cycle_start_time[11:0];
      count_reg   <= rx_cycle_start_time[24:12];
      seconds_reg <= rx_cycle_start_time[31:25];
    end else if (bus_side_ctl_flags_reg[hlc_pkg::BS_RUN_BIT]) begin
      if (rollover) begin
        offset_reg <= 12'h000;
        if (count_reg == 13'(hlc_pkg::CYCLES_PER_SECOND - 1)) begin
          count_reg   <= 13'h0000;
          seconds_reg <= seconds_reg + 7'h01;
        end else begin
          count_reg <= count_reg + 13'h0001;
        end
      end else if (tick_24m) begin
        offset_reg <= offset_reg + 12'h001;
      end
    end
  end

  // Cycle start emission on each rollover while running, link active and root originator
  always_ff @(posedge clk) begin
    if (!reset_n || soft_busy) begin
      cycle_start_send <= 1'b0;
    end else begin
      cycle_start_send <= rollover && root_reg && link_active
        && bus_side_ctl_flags_reg[hlc_pkg::BS_RUN_BIT]
        && bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT];
    end
  end

  // Byte lane steering; headers and untouched codes pass big endian
  always_comb begin
    unique case (pkt_tcode)
      hlc_pkg::TC_QUAD_WRITE, hlc_pkg::TC_BLOCK_WRITE, hlc_pkg::TC_QUAD_RESP,
      hlc_pkg::TC_BLOCK_RESP, hlc_pkg::TC_STREAM, hlc_pkg::TC_LOCK_REQ,
      hlc_pkg::TC_LOCK_RESP: swap_code = 1'b1;
      default:               swap_code = 1'b0;
    endcase
  end
  assign do_swap = swap_code && !pkt_is_header
    && !host_ctl_flags_reg[hlc_pkg::HC_BIG_ENDIAN_BIT];

  // Registered data path and status outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      quadlet_out             <= 32'h0000_0000;
      link_active             <= 1'b0;
      early_ack_writes_on     <= 1'b0;
      accept_phy_packets      <= 1'b0;
      accept_identity_packets <= 1'b0;
      controller_reset        <= 1'b0;
      cycle_time_out          <= 32'h0000_0000;
    end else begin
      quadlet_out <= do_swap ? {quadlet_in[7:0], quadlet_in[15:8],
                                quadlet_in[23:16], quadlet_in[31:24]}
                             : quadlet_in;
      link_active <= host_ctl_flags_reg[hlc_pkg::HC_ATTACH_BIT] && !soft_busy;
      early_ack_writes_on <= host_ctl_flags_reg[hlc_pkg::HC_EARLY_ACK_BIT];
      accept_phy_packets <= bus_side_ctl_flags_reg[hlc_pkg::BS_PHY_PKT_BIT]
        && async_receive_enabled && host_ctl_flags_reg[hlc_pkg::HC_ATTACH_BIT];
      accept_identity_packets <= bus_side_ctl_flags_reg[hlc_pkg::BS_IDENT_PKT_BIT]
        && host_ctl_flags_reg[hlc_pkg::HC_ATTACH_BIT];
      controller_reset <= soft_busy;
      cycle_time_out <= {seconds_reg, count_reg, offset_reg};
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!reset_n || !reg_read) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        hlc_pkg::HOST_SET_ADDR, hlc_pkg::HOST_CLEAR_ADDR:
          reg_rdata <= host_ctl_flags_reg;
        hlc_pkg::BUS_SET_ADDR, hlc_pkg::BUS_CLEAR_ADDR:
          reg_rdata <= bus_side_ctl_flags_reg;
        hlc_pkg::TIMER_ADDR: reg_rdata <= {seconds_reg, count_reg, offset_reg};
        hlc_pkg::EVENT_ADDR: reg_rdata <= {31'h0, overlong_flag_reg};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  sequence s_set_host_attach;
    reg_write && reg_addr == hlc_pkg::HOST_SET_ADDR
      && reg_wdata[hlc_pkg::HC_ATTACH_BIT] && !soft_busy;
  endsequence

  a_set_bit_sticks: assert property (@(posedge clk) disable iff (!reset_n)
    s_set_host_attach |=> host_ctl_flags_reg[hlc_pkg::HC_ATTACH_BIT])
    else $error("set write did not set attach bit");
  a_clear_bit_drops: assert property (@(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == hlc_pkg::BUS_CLEAR_ADDR && !soft_busy
      && reg_wdata[hlc_pkg::BS_RUN_BIT]
      |=> !bus_side_ctl_flags_reg[hlc_pkg::BS_RUN_BIT])
    else $error("clear write did not clear run bit");
  a_read_host_value: assert property (@(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == hlc_pkg::HOST_CLEAR_ADDR
      |=> reg_rdata == $past(host_ctl_flags_reg))
    else $error("clear address read mismatch");
  a_self_reset_attach: assert property (@(posedge clk) disable iff (!reset_n)
    soft_busy |=> !host_ctl_flags_reg[hlc_pkg::HC_ATTACH_BIT] ##1 !link_active)
    else $error("attach survived self reset");
  a_self_reset_ends: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(soft_busy) |-> soft_busy[*4] ##1 !soft_busy)
    else $error("self reset length wrong");
  a_overlong_clears: assert property (@(posedge clk) disable iff (!reset_n)
    overlong_cycle_event |=> !bus_side_ctl_flags_reg[hlc_pkg::BS_ORIGINATOR_BIT])
    else $error("originator survived overlong event");
  a_header_not_swapped: assert property (@(posedge clk) disable iff (!reset_n)
    pkt_is_header |=> quadlet_out == $past(quadlet_in))
    else $error("header quadlet was swapped");
  a_offset_holds: assert property (@(posedge clk) disable iff (!reset_n)
    !bus_side_ctl_flags_reg[hlc_pkg::BS_RUN_BIT] && !rx_cycle_start_valid && !soft_busy
      |=> $stable(offset_reg))
    else $error("offset moved while stopped");
endmodule

/* File: rtl/hlc_pkg.sv */
// Shared constants for the host link control register bank
package hlc_pkg;
  // Register port addresses, word index on the plain port
  localparam logic [3:0] HOST_SET_ADDR   = 4'h0;
  localparam logic [3:0] HOST_CLEAR_ADDR = 4'h1;
  localparam logic [3:0] BUS_SET_ADDR    = 4'h2;
  localparam logic [3:0] BUS_CLEAR_ADDR  = 4'h3;
  localparam logic [3:0] TIMER_ADDR      = 4'h4;
  localparam logic [3:0] EVENT_ADDR      = 4'h5;
  // Host control field positions
  localparam int HC_BIG_ENDIAN_BIT = 30;
  localparam int HC_EARLY_ACK_BIT  = 18;
  localparam int HC_ATTACH_BIT     = 17;
  localparam int HC_SELF_RESET_BIT = 16;
  // Bus side control field positions
  localparam int BS_EXT_TICK_BIT   = 22;
  localparam int BS_ORIGINATOR_BIT = 21;
  localparam int BS_RUN_BIT        = 20;
  localparam int BS_PHY_PKT_BIT    = 10;
  localparam int BS_IDENT_PKT_BIT  = 9;
  // Event flag position and reset values
  localparam int EV_OVERLONG_BIT = 0;
  localparam logic [31:0] HOST_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] BUS_RESET_VALUE  = 32'h0000_0000;
  localparam logic [31:0] HOST_WRITABLE    = 32'h4007_0000;
  localparam logic [31:0] BUS_WRITABLE     = 32'h0070_0600;
  // Timer layout
  localparam int OFFSET_BITS  = 12;
  localparam int COUNT_BITS   = 13;
  localparam int SECONDS_BITS = 7;
  localparam int CYCLE_TICKS  = 3072;
  localparam int CYCLES_PER_SECOND = 8000;
  // Self reset duration in clk cycles
  localparam int SELF_RESET_CYCLES = 4;
  // Transaction codes
  localparam logic [3:0] TC_QUAD_WRITE  = 4'h0;
  localparam logic [3:0] TC_BLOCK_WRITE = 4'h1;
  localparam logic [3:0] TC_QUAD_RESP   = 4'h6;
  localparam logic [3:0] TC_BLOCK_RESP  = 4'h7;
  localparam logic [3:0] TC_STREAM      = 4'h9;
  localparam logic [3:0] TC_CYCLE_START = 4'h8;
  localparam logic [3:0] TC_LOCK_REQ    = 4'hA;
  localparam logic [3:0] TC_LOCK_RESP   = 4'hB;
  localparam logic [3:0] TC_PHY_PACKET  = 4'hE;
endpackage

/* File: test/hlc_regs_tb.sv */
// Self-checking bench for the host link control register bank
`timescale 1ns/1ps
module hlc_regs_tb;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] data;
    logic [3:0]  lv;
    logic        lv_on;
  } hlc_note_type;
  logic         clk, reset_n, reg_write, reg_read, tick_24m, ext_tick;
  logic         bus_reset_active, phy_is_root, overlong_cycle_event;
  logic         async_receive_enabled, rx_cycle_start_valid, pkt_is_header;
  logic         link_active, early_ack_writes_on, accept_phy_packets;
  logic         accept_identity_packets, cycle_start_send, controller_reset;
  logic [3:0]   reg_addr, pkt_tcode;
  logic [31:0]  reg_wdata, reg_rdata, rx_cycle_start_time, quadlet_in;
  logic [31:0]  quadlet_out, cycle_time_out, host_m, bus_m, rng;
  logic         rd_seen, qd_seen, qd_drive;
  hlc_note_type rd_q[$];
  logic [31:0]  qd_q[$];
  int           err_total, num_checks, cs_cnt;

  hlc_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tick_24m(tick_24m), .ext_tick(ext_tick), .bus_reset_active(bus_reset_active),
    .phy_is_root(phy_is_root), .overlong_cycle_event(overlong_cycle_event),
    .async_receive_enabled(async_receive_enabled),
    .rx_cycle_start_valid(rx_cycle_start_valid), .rx_cycle_start_time(rx_cycle_start_time),
    .pkt_tcode(pkt_tcode), .pkt_is_header(pkt_is_header), .quadlet_in(quadlet_in),
    .quadlet_out(quadlet_out), .link_active(link_active),
    .early_ack_writes_on(early_ack_writes_on), .accept_phy_packets(accept_phy_packets),
    .accept_identity_packets(accept_identity_packets),
    .cycle_start_send(cycle_start_send), .cycle_time_out(cycle_time_out),
    .controller_reset(controller_reset));

  // Xorshift source, seeded at 12 for a repeatable run
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected read data from the shadow model; unmapped and idle places read 0
  function automatic logic [31:0] exp_rd(logic [3:0] a);
    case (a)
      hlc_pkg::HOST_SET_ADDR, hlc_pkg::HOST_CLEAR_ADDR: return host_m;
      hlc_pkg::BUS_SET_ADDR, hlc_pkg::BUS_CLEAR_ADDR: return bus_m;
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk32(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes stay up across back-to-back calls; cyc drops both strobes, the tick, the quadlet drive and the overlong event
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFF_FFFF,
                    logic lo = 1'b1);
    hlc_note_type n;
    n = '{m, e & m, {host_m[17], host_m[18], bus_m[10] & async_receive_enabled & host_m[17],
                     bus_m[9] & host_m[17]}, lo};
    rd_q.push_back(n);
    reg_addr  <= a;
    reg_read  <= 1'b1;
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cyc(int n);
    {reg_write, reg_read, tick_24m, qd_drive, overlong_cycle_event} <= '0;
    repeat (n) @(posedge clk);
  endtask

  task automatic qd(logic [3:0] tc, logic hd, logic [31:0] d);
    logic sw;
    sw = !hd && !host_m[30] && (tc inside {4'h0, 4'h1, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB});
    qd_q.push_back(sw ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d);
    pkt_tcode     <= tc;
    pkt_is_header <= hd;
    quadlet_in    <= d;
    qd_drive      <= 1'b1;
    @(posedge clk);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Results land one cycle after their request; judged mid-cycle once settled
  always @(posedge clk) begin
    rd_seen <= reg_read;
    qd_seen <= qd_drive;
    if (cycle_start_send === 1'b1) cs_cnt <= cs_cnt + 1;
  end

  always @(negedge clk) begin : watch
    hlc_note_type n;
    if (rd_seen === 1'b1) begin
      n = rd_q.pop_front();
      chk32(reg_rdata & n.mask, n.data);
      if (n.lv_on) chk32({28'h0, link_active, early_ack_writes_on, accept_phy_packets,
                          accept_identity_packets}, {28'h0, n.lv});
    end
    if (qd_seen === 1'b1) chk32(quadlet_out, qd_q.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far beyond the longest sequence
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [31:0] a;
    logic [31:0] d;
    {reset_n, reg_write, reg_read, tick_24m, ext_tick, bus_reset_active} = '0;
    {phy_is_root, overlong_cycle_event, async_receive_enabled, rx_cycle_start_valid} = '0;
    {pkt_is_header, rd_seen, qd_seen, qd_drive, reg_addr, pkt_tcode} = '0;
    {reg_wdata, rx_cycle_start_time, quadlet_in, host_m, bus_m} = '0;
    {err_total, num_checks, cs_cnt} = '0;
    rng = 32'hC;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(hlc_pkg::HOST_SET_ADDR, 32'h0);
    rd(hlc_pkg::BUS_CLEAR_ADDR, 32'h0);
    // Random set and clear traffic, each write followed by a read of a random address
    for (int i = 0; i < 200; i++) begin
      a = xs();
      d = xs() & ~32'h0001_0000;
      async_receive_enabled <= a[8];
      wr({2'h0, a[1:0]}, d);
      case (a[1:0])
        2'h0: host_m = host_m | (d & hlc_pkg::HOST_WRITABLE);
        2'h1: host_m = host_m & ~d;
        2'h2: bus_m = bus_m | (d & hlc_pkg::BUS_WRITABLE);
        default: bus_m = bus_m & ~d;
      endcase
      rd(a[5:2], exp_rd(a[5:2]));
    end
    // Overlong event drops the originator and blocks setting it until cleared
    wr(hlc_pkg::BUS_CLEAR_ADDR, 32'hFFFF_FFFF);
    wr(hlc_pkg::BUS_SET_ADDR, 32'h0020_0000);
    overlong_cycle_event <= 1'b1;
    wr(hlc_pkg::BUS_SET_ADDR, 32'h0);
    overlong_cycle_event <= 1'b0;
    bus_m = 32'h0;
    wr(hlc_pkg::BUS_SET_ADDR, 32'h0020_0000);
    rd(hlc_pkg::BUS_SET_ADDR, 32'h0);
    rd(hlc_pkg::EVENT_ADDR, 32'h1);
    wr(hlc_pkg::EVENT_ADDR, 32'h1);
    rd(hlc_pkg::EVENT_ADDR, 32'h0);
    wr(hlc_pkg::BUS_SET_ADDR, 32'h0020_0000);
    bus_m = 32'h0020_0000;
    rd(hlc_pkg::BUS_CLEAR_ADDR, bus_m);
    // Every code with and without header, little then big endian payload
    for (int b = 0; b < 2; b++) begin
      wr(b ? hlc_pkg::HOST_SET_ADDR : hlc_pkg::HOST_CLEAR_ADDR, 32'h4000_0000);
      host_m[30] = b[0];
      cyc(1);
      for (int t = 0; t < 32; t++) qd(t[3:0], t[4], xs());
      cyc(1);
    end
    // Offset holds while stopped, then counts and rolls over at 3072 ticks
    wr(hlc_pkg::BUS_CLEAR_ADDR, 32'hFFFF_FFFF);
    bus_m = 32'h0;
    cyc(1);
    tick_24m <= 1'b1;
    repeat (5) @(posedge clk);
    rd(hlc_pkg::TIMER_ADDR, 32'h0);
    bus_reset_active <= 1'b1;
    phy_is_root      <= 1'b1;
    cyc(2);
    bus_reset_active <= 1'b0;
    phy_is_root      <= 1'b0;
    wr(hlc_pkg::BUS_SET_ADDR, 32'h0030_0000);
    wr(hlc_pkg::HOST_SET_ADDR, 32'h0002_0000);
    bus_m  = 32'h0030_0000;
    host_m = host_m | 32'h0002_0000;
    cyc(1);
    tick_24m <= 1'b1;
    @(posedge clk);
    repeat (4) @(posedge clk);
    cyc(1);
    rd(hlc_pkg::TIMER_ADDR, 32'h5);
    chk32(cs_cnt, 32'h0);
    tick_24m <= 1'b1;
    repeat (3069) @(posedge clk);
    cyc(4);
    chk32(cs_cnt, 32'h1);
    chk32(cycle_time_out, {7'h0, 13'h1, 12'h2});
    rd(hlc_pkg::TIMER_ADDR, {7'h0, 13'h1, 12'h2});
    // Self reset: busy flag, refused write, then all back to reset values
    wr(hlc_pkg::HOST_SET_ADDR, 32'h0001_0000);
    rd(hlc_pkg::HOST_SET_ADDR, 32'h0001_0000, 32'h0001_0000, 1'b0);
    wr(hlc_pkg::HOST_SET_ADDR, 32'h0002_0000);
    cyc(1);
    chk1(controller_reset, 1'b1);
    cyc(8);
    host_m = 32'h0;
    bus_m  = 32'h0;
    rd(hlc_pkg::HOST_CLEAR_ADDR, 32'h0);
    rd(hlc_pkg::BUS_SET_ADDR, 32'h0);
    // Attached non-originator reloads its timer from a received cycle start
    wr(hlc_pkg::HOST_SET_ADDR, 32'h0002_0000);
    host_m = 32'h0002_0000;
    cyc(1);
    rx_cycle_start_time  <= 32'h0123_4567;
    rx_cycle_start_valid <= 1'b1;
    @(posedge clk);
    rx_cycle_start_valid <= 1'b0;
    rd(hlc_pkg::TIMER_ADDR, 32'h0123_4567);
    cyc(2);
    chk1(controller_reset, 1'b0);
    report_and_stop();
  end
endmodule
